// [design/program_space_access_mapper.sv]
// Program space access mapper: address building, data steering, stalls.
// Assumes an APB master for the page registers and a program memory that
// returns the addressed word one cycle after the request.
// Functional notes
// - Table address is table page above the 16-bit effective address.
// - Table page top bit chooses user or configuration space.
// - Configuration space allows reads only; table writes there are refused.
// - Table effective addresses need not be word aligned.
// - Fetch address: bit 23 zero, PC bits 22..1, bit 0 zero.
// - Word table read low returns program bits 15..0 unchanged.
// - Byte table read low returns upper or lower byte per byte select.
// - Word table read high returns bits 23..16, upper byte zero.
// - Byte table read high returns upper byte, or zero when select set.
// - Low variants touch the low word, high variants the upper byte.
// - Program counter steps by two per program word.
// - Window redirect only when EA top bit and window enable set.
// - Window address: zero, window page, EA bits 14..0.
// - Window covers 8000h upward, one of 256 pages of 32K words.
// - Window reads deliver only the low sixteen program bits.
// - A window read stretches the instruction by up to two extra cycles.
// - Outside loops: moves cost one extra cycle, others two.
// - In loops: first, last, interrupt exit and re-entry cost two.
// - Window redirect is suspended during table reads and writes.
// - Table page register is eight bits, choosing a 64K-word region.
`timescale 1ns/1ps
module program_space_access_mapper
(
  input  wire logic               core_clk,
  input  wire logic               reset_n,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire psam_pkg::cpu_req_s cpuReq,
  input  wire logic               byteSel,
  output logic [15:0]             readData,
  output logic                    readValid,
  output logic                    stall,
  output logic                    writeRefused,
  output psam_pkg::prog_req_s     progReq,
  input  wire logic [23:0]        progWord
);

  logic [7:0]        tablePage_q;
  logic [7:0]        windowPage_q;
  logic [15:0]       cpuCtrl_q;
  logic [23:0]       genAddr;
  logic              windowHit;
  logic              configSpace;
  logic              isTable;
  logic              isWrite;
  logic              refuse;
  logic              apbWrite;
  logic              apbHit;
  logic [1:0]        stallCnt_q;
  logic [1:0]        stallCnt_d;
  logic              refused_q;
  logic [15:0]       readData_q;
  logic              readValid_q;
  psam_pkg::access_e pendKind_q;
  logic              pendByte_q;
  logic              pendSel_q;
  logic [15:0]       steered;

  // Every check in this module runs on the core clock and rests in reset.
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  // Address builder shared by fetch, table and window paths.
  psam_addr_gen psam_addr_gen_i
  (
    .req         (cpuReq),
    .tablePage   (tablePage_q),
    .windowPage  (windowPage_q),
    .windowEn    (cpuCtrl_q[psam_pkg::CTRL_WIN_BIT]),
    .progAddr    (genAddr),
    .windowHit   (windowHit),
    .configSpace (configSpace)
  );

  // Read data steering works on the request captured last cycle.
  psam_read_steer psam_read_steer_i
  (
    .kind     (pendKind_q),
    .byteMode (pendByte_q),
    .byteSel  (pendSel_q),
    .progWord (progWord),
    .data     (steered)
  );

  // Classify the request for refusal and memory direction.
  assign isTable = (cpuReq.kind == psam_pkg::ACC_TRDL) ||
                   (cpuReq.kind == psam_pkg::ACC_TRDH) ||
                   (cpuReq.kind == psam_pkg::ACC_TWRL) ||
                   (cpuReq.kind == psam_pkg::ACC_TWRH);
  assign isWrite = (cpuReq.kind == psam_pkg::ACC_TWRL) ||
                   (cpuReq.kind == psam_pkg::ACC_TWRH);
  assign refuse  = isWrite & configSpace;

  // The memory request is combinational so it lands in the issue cycle.
  always_comb
  begin
    progReq.addr     = genAddr;
    progReq.write    = isWrite & ~refuse;
    progReq.highPart = (cpuReq.kind == psam_pkg::ACC_TRDH) ||
                       (cpuReq.kind == psam_pkg::ACC_TWRH);
    progReq.valid    = ((cpuReq.kind == psam_pkg::ACC_FETCH) ||
                        (isTable & ~refuse) || windowHit) &&
                       (stallCnt_q == psam_pkg::STALL_NONE);
  end

  // APB slave: zero wait states, unmapped offsets answer with an error.
  assign apbWrite = psel & penable & pwrite;
  assign apbHit   = (paddr == psam_pkg::TABLE_PAGE_OFS) ||
                    (paddr == psam_pkg::WINDOW_PAGE_OFS) ||
                    (paddr == psam_pkg::CPU_CTRL_OFS) ||
                    (paddr == psam_pkg::STATUS_OFS);
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~apbHit;

  // Page and control registers written by software.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tablePage_q  <= psam_pkg::TABLE_PAGE_RST;
      windowPage_q <= psam_pkg::WINDOW_PAGE_RST;
      cpuCtrl_q    <= psam_pkg::CPU_CTRL_RST;
    end
    else if (apbWrite)
    begin
      if (paddr == psam_pkg::TABLE_PAGE_OFS)
        tablePage_q <= pwdata[7:0];
      if (paddr == psam_pkg::WINDOW_PAGE_OFS)
        windowPage_q <= pwdata[7:0];
      if (paddr == psam_pkg::CPU_CTRL_OFS)
        cpuCtrl_q <= pwdata[15:0];
    end
  end

  // Read mux; the status word shows stall count and last refusal.
  always_comb
  begin
    prdata = 32'h00000000;
    case (paddr)
      psam_pkg::TABLE_PAGE_OFS:  prdata = {24'h000000, tablePage_q};
      psam_pkg::WINDOW_PAGE_OFS: prdata = {24'h000000, windowPage_q};
      psam_pkg::CPU_CTRL_OFS:    prdata = {16'h0000, cpuCtrl_q};
      psam_pkg::STATUS_OFS:
        prdata = {29'h00000000, refused_q, stallCnt_q};
      default:                   prdata = 32'h00000000;
    endcase
  end

  // Extra cycles for a window read, by instruction class and loop state.
  always_comb
  begin
    stallCnt_d = stallCnt_q;
    if (stallCnt_q != psam_pkg::STALL_NONE)
      stallCnt_d = stallCnt_q - 2'h1;
    else if (windowHit && cpuReq.inRepeat)
      stallCnt_d = cpuReq.repeatEdge ? psam_pkg::STALL_LOOP
                                     : psam_pkg::STALL_NONE;
    else if (windowHit)
      stallCnt_d = cpuReq.moveInstr ? psam_pkg::STALL_MOVE
                                    : psam_pkg::STALL_OTHER;
  end

  // Stall counter; the CPU holds its request while stall is high.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      stallCnt_q <= psam_pkg::STALL_NONE;
    else
      stallCnt_q <= stallCnt_d;
  end

  assign stall = (stallCnt_q != psam_pkg::STALL_NONE);

  // Sticky refusal flag; a new refusal wins over the software clear.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      refused_q <= 1'b0;
    else if (refuse)
      refused_q <= 1'b1;
    else if (apbWrite && paddr == psam_pkg::STATUS_OFS && pwdata[2])
      refused_q <= 1'b0;
  end

  assign writeRefused = refused_q;

  // Capture the read request so the word returned next cycle is steered.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pendKind_q <= psam_pkg::ACC_NONE;
      pendByte_q <= 1'b0;
      pendSel_q  <= 1'b0;
    end
    else if (progReq.valid && !progReq.write)
    begin
      pendKind_q <= cpuReq.kind;
      pendByte_q <= cpuReq.byteMode;
      pendSel_q  <= byteSel;
    end
    else
    begin
      pendKind_q <= psam_pkg::ACC_NONE;
      pendByte_q <= 1'b0;
      pendSel_q  <= 1'b0;
    end
  end

  // Registered data result; fetches are not returned on this path.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      readData_q  <= 16'h0000;
      readValid_q <= 1'b0;
    end
    else
    begin
      readValid_q <= (pendKind_q == psam_pkg::ACC_TRDL) ||
                     (pendKind_q == psam_pkg::ACC_TRDH) ||
                     (pendKind_q == psam_pkg::ACC_DATA);
      readData_q  <= steered;
    end
  end

  assign readData  = readData_q;
  assign readValid = readValid_q;

  // Table address carries the page above the effective address.
  a_table_addr: assert property (
    isTable |-> progReq.addr == {tablePage_q, cpuReq.ea})
    else $error("table address wrong");

  // Configuration writes never reach memory.
  a_cfg_no_write: assert property (
    (isWrite && tablePage_q[psam_pkg::TBL_CFG_BIT]) |->
      !progReq.write ##1 refused_q)
    else $error("config write not refused");

  // Configuration reads still go out to memory, with bit 23 set.
  a_cfg_read_go: assert property (
    (isTable && !isWrite && configSpace && !stall) |->
      progReq.valid && !progReq.write && progReq.addr[23])
    else $error("config read blocked");

  // User space table writes go out as writes.
  a_user_write_go: assert property (
    (isWrite && !configSpace && !stall) |-> progReq.valid && progReq.write)
    else $error("user write blocked");

  // An odd effective address passes to memory untouched.
  a_odd_ea_kept: assert property (
    (isTable && cpuReq.ea[0]) |-> progReq.addr[0])
    else $error("odd table address aligned");

  // Fetch address has fixed zero ends.
  a_fetch_addr: assert property (
    cpuReq.kind == psam_pkg::ACC_FETCH |->
      progReq.addr == {1'b0, cpuReq.pc[22:1], 1'b0})
    else $error("fetch address wrong");

  // Word read low returns the low program word two edges later.
  a_rdl_word: assert property (
    (progReq.valid && cpuReq.kind == psam_pkg::ACC_TRDL && !cpuReq.byteMode)
      ##1 1'b1 |=> readValid && readData == $past(progWord[15:0]))
    else $error("read low word wrong");

  // Byte read low moves the selected byte of the low word.
  a_rdl_byte: assert property (
    (progReq.valid && cpuReq.kind == psam_pkg::ACC_TRDL && cpuReq.byteMode)
      ##1 1'b1 |=> readValid && readData[7:0] == ($past(byteSel, 2) ?
      $past(progWord[15:8]) : $past(progWord[7:0])))
    else $error("read low byte wrong");

  // Word read high forces the phantom byte to zero.
  a_rdh_phantom: assert property (
    (readValid && $past(pendKind_q) == psam_pkg::ACC_TRDH) |->
      readData[15:8] == 8'h00)
    else $error("phantom byte not zero");

  // Byte read high gives the upper byte, or zero for the phantom one.
  a_rdh_byte: assert property (
    (progReq.valid && cpuReq.kind == psam_pkg::ACC_TRDH && cpuReq.byteMode)
      ##1 1'b1 |=> readValid && readData == ($past(byteSel, 2) ? 16'h0000 :
      {8'h00, $past(progWord[23:16])}))
    else $error("read high byte wrong");

  // Window address built from the window page.
  a_window_addr: assert property (
    windowHit |-> progReq.addr == {1'b0, windowPage_q, cpuReq.ea[14:0]} &&
      cpuReq.ea[psam_pkg::EA_TOP_BIT] && cpuCtrl_q[psam_pkg::CTRL_WIN_BIT])
    else $error("window address wrong");

  // Data addresses below the window are never redirected.
  a_below_window: assert property (
    (cpuReq.kind == psam_pkg::ACC_DATA && !cpuReq.ea[psam_pkg::EA_TOP_BIT])
      |-> !windowHit && !progReq.valid)
    else $error("redirect below window");

  // Window reads hand over only the low sixteen program bits.
  a_window_data: assert property (
    (progReq.valid && windowHit) ##1 1'b1 |=>
      readValid && readData == $past(progWord[15:0]))
    else $error("window data wrong");

  // A non-move window access outside loops stalls exactly two cycles.
  a_window_stall: assert property (
    (windowHit && !stall && !cpuReq.inRepeat && !cpuReq.moveInstr) |=>
      stall [*2] ##1 !stall)
    else $error("window stall length wrong");

  // A move through the window outside loops stalls exactly one cycle.
  a_window_move: assert property (
    (windowHit && !stall && !cpuReq.inRepeat && cpuReq.moveInstr) |=>
      stall ##1 !stall)
    else $error("window move stall wrong");

  // Costly loop iterations stall exactly two cycles.
  a_loop_edge: assert property (
    (windowHit && !stall && cpuReq.inRepeat && cpuReq.repeatEdge) |=>
      stall [*2] ##1 !stall)
    else $error("loop edge stall wrong");

  // Inner loop iterations run through the window without a stall.
  a_loop_cheap: assert property (
    (windowHit && !stall && cpuReq.inRepeat && !cpuReq.repeatEdge) |=>
      !stall)
    else $error("loop inner stall wrong");

  // Table operations never redirect through the window.
  a_table_no_win: assert property (
    isTable |-> !windowHit)
    else $error("window active in table op");

  // An accepted table request reaches memory in its own cycle.
  a_table_issue: assert property (
    (isTable && !refuse && !stall) |-> progReq.valid)
    else $error("table request not issued");

endmodule

// [design/psam_addr_gen.sv]
// Combinational program address builder for all access paths.
// Assumes page registers are stable while a request is presented.
`timescale 1ns/1ps
module psam_addr_gen
(
  input  wire psam_pkg::cpu_req_s req,
  input  wire logic [7:0]         tablePage,
  input  wire logic [7:0]         windowPage,
  input  wire logic               windowEn,
  output logic [23:0]             progAddr,
  output logic                    windowHit,
  output logic                    configSpace
);

  // Table paths win over the window, which is suspended during them.
  always_comb
  begin
    windowHit   = 1'b0;
    configSpace = 1'b0;
    progAddr    = 24'h000000;
    case (req.kind)
      psam_pkg::ACC_FETCH:
      begin
        progAddr = {1'b0, req.pc[22:1], 1'b0};
      end
      psam_pkg::ACC_TRDL, psam_pkg::ACC_TRDH,
      psam_pkg::ACC_TWRL, psam_pkg::ACC_TWRH:
      begin
        progAddr    = {tablePage, req.ea};
        configSpace = tablePage[psam_pkg::TBL_CFG_BIT];
      end
      psam_pkg::ACC_DATA:
      begin
        windowHit = req.ea[psam_pkg::EA_TOP_BIT] & windowEn;
        if (windowHit)
        begin
          progAddr = {1'b0, windowPage, req.ea[14:0]};
        end
      end
      default:
      begin
        progAddr = 24'h000000;
      end
    endcase
  end

endmodule

// [design/psam_pkg.sv]
// Package with the constants and carrier types of the program space mapper.
// Assumes a 16-bit data path and a 24-bit program word on the far side.
package psam_pkg;

  // Widths of the two address spaces and of the page registers.
  localparam int PADDR_W = 24;
  localparam int EA_W    = 16;
  localparam int PAGE_W  = 8;

  // Bit positions used by the address builder.
  localparam int TBL_CFG_BIT  = 7;
  localparam int EA_TOP_BIT   = 15;
  localparam int CTRL_WIN_BIT = 2;

  // Reset values of the software-visible page and control registers.
  localparam logic [7:0]  TABLE_PAGE_RST  = 8'h00;
  localparam logic [7:0]  WINDOW_PAGE_RST = 8'h00;
  localparam logic [15:0] CPU_CTRL_RST    = 16'h0000;

  // Extra cycles charged for window accesses.
  localparam logic [1:0] STALL_MOVE  = 2'h1;
  localparam logic [1:0] STALL_OTHER = 2'h2;
  localparam logic [1:0] STALL_LOOP  = 2'h2;
  localparam logic [1:0] STALL_NONE  = 2'h0;

  // APB register offsets, byte addresses.
  localparam logic [11:0] TABLE_PAGE_OFS  = 12'h000;
  localparam logic [11:0] WINDOW_PAGE_OFS = 12'h004;
  localparam logic [11:0] CPU_CTRL_OFS    = 12'h008;
  localparam logic [11:0] STATUS_OFS      = 12'h00C;

  // Kinds of access the CPU may request.
  typedef enum logic [2:0]
  {
    ACC_NONE  = 3'b000,
    ACC_FETCH = 3'b001,
    ACC_DATA  = 3'b010,
    ACC_TRDL  = 3'b011,
    ACC_TRDH  = 3'b100,
    ACC_TWRL  = 3'b101,
    ACC_TWRH  = 3'b110
  } access_e;

  // One request from the CPU datapath.
  typedef struct packed
  {
    access_e     kind;
    logic        byteMode;
    logic [15:0] ea;
    logic [22:0] pc;
    logic        moveInstr;
    logic        inRepeat;
    logic        repeatEdge;
  } cpu_req_s;

  // One request to the program memory port.
  typedef struct packed
  {
    logic        valid;
    logic        write;
    logic        highPart;
    logic [23:0] addr;
  } prog_req_s;

endpackage

// [design/psam_read_steer.sv]
// Steers a 24-bit program word onto the 16-bit data result.
// Assumes the word is the one addressed by the current request.
`timescale 1ns/1ps
module psam_read_steer
(
  input  wire psam_pkg::access_e kind,
  input  wire logic              byteMode,
  input  wire logic              byteSel,
  input  wire logic [23:0]       progWord,
  output logic [15:0]            data
);

  // Low reads see only P<15:0>, high reads only P<23:16>.
  always_comb
  begin
    data = 16'h0000;
    case (kind)
      psam_pkg::ACC_TRDL:
      begin
        if (!byteMode)
          data = progWord[15:0];
        else if (byteSel)
          data = {8'h00, progWord[15:8]};
        else
          data = {8'h00, progWord[7:0]};
      end
      psam_pkg::ACC_TRDH:
      begin
        if (!byteMode)
          data = {8'h00, progWord[23:16]};
        else if (byteSel)
          data = 16'h0000;
        else
          data = {8'h00, progWord[23:16]};
      end
      psam_pkg::ACC_DATA:
      begin
        data = progWord[15:0];
      end
      default:
      begin
        data = 16'h0000;
      end
    endcase
  end

endmodule

// [verif/prog_mem_model.sv]
// Program memory stand-in on the far side of the mapper's read port.
// Assumes the mapper's request is settled before each rising clock edge.
`timescale 1ns/1ps
module prog_mem_model
(
  input  wire logic                core_clk,
  input  wire psam_pkg::prog_req_s progReq,
  output logic [23:0]              progWord
);
  logic [23:0] word_q = 24'h000000;

  // A read is answered one cycle later with a word derived from the
  // address. Without a read the port toggles, so stale data never passes.
  always @(posedge core_clk)
  begin
    if (progReq.valid && !progReq.write)
      word_q <= {progReq.addr[7:0] ^ 8'h5A, progReq.addr[15:0] ^ 16'hC3C3};
    else
      word_q <= ~word_q;
  end

  // The answer is driven straight from the holding register.
  assign progWord = word_q;
endmodule

// [verif/tb_program_space_access_mapper.sv]
// Self-checking bench for the program space mapper.
// Assumes the memory model answers reads one cycle after the request.
`timescale 1ns/1ps
module tb_program_space_access_mapper;
  localparam logic [4:0] WINF[4] = '{5'h00, 5'h04, 5'h03, 5'h02};
  localparam int         WINS[4] = '{2, 1, 2, 0};

  logic                core_clk = 1'b0;
  logic                reset_n  = 1'b0;
  logic                psel     = 1'b0;
  logic                penable  = 1'b0;
  logic                pwrite   = 1'b0;
  logic [11:0]         paddr    = 12'h000;
  logic [31:0]         pwdata   = 32'h0;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  psam_pkg::cpu_req_s  cpuReq   = '0;
  logic                byteSel  = 1'b0;
  logic [15:0]         readData;
  logic                readValid;
  logic                stall;
  logic                writeRefused;
  psam_pkg::prog_req_s progReq;
  logic [23:0]         progWord;
  psam_pkg::prog_req_s pq;
  logic [15:0]         rdd;
  int                  stalls;
  int                  rdv;
  int                  badCount = 0;
  int                  samplesChecked = 0;

  program_space_access_mapper program_space_access_mapper_i
  (
    .core_clk(core_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpuReq(cpuReq),
    .byteSel(byteSel), .readData(readData), .readValid(readValid),
    .stall(stall), .writeRefused(writeRefused), .progReq(progReq),
    .progWord(progWord)
  );

  prog_mem_model prog_mem_model_i
  (
    .core_clk(core_clk), .progReq(progReq), .progWord(progWord)
  );

  // Free-running 50 MHz clock.
  always #10 core_clk = ~core_clk;

  // Expected memory content, kept apart from the model on purpose.
  function automatic logic [23:0] mw(input logic [23:0] a);
    return {a[7:0] ^ 8'h5A, a[15:0] ^ 16'hC3C3};
  endfunction

  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    samplesChecked++;
    if (g !== e)
    begin
      badCount++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic er);
    @(posedge core_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // One CPU request, held through the stall it should cost, then watched.
  task automatic acc(input psam_pkg::access_e k, input logic [4:0] f,
                     input logic [15:0] ea, input logic [22:0] pc,
                     input int hold);
    @(posedge core_clk);
    cpuReq  <= '{k, f[4], ea, pc, f[2], f[1], f[0]};
    byteSel <= f[3];
    @(negedge core_clk);
    pq     = progReq;
    stalls = 0;
    rdv    = 0;
    rdd    = 'x;
    for (int i = 0; i < 6; i++)
    begin
      @(posedge core_clk);
      if (i == hold)
        cpuReq <= '0;
      @(negedge core_clk);
      if (stall === 1'b1)
        stalls++;
      if (readValid === 1'b1)
      begin
        rdv++;
        rdd = readData;
      end
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic reportAndStop;
    $display("checks %0d mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Cuts a hang short well beyond the fewer than two hundred cycles the tests need.
  initial
  begin
    #(20 * 5000);
    badCount++;
    reportAndStop();
  end

  // Main sequence.
  initial
  begin
    logic [31:0]       rd;
    logic              er;
    logic [23:0]       w;
    logic [15:0]       e;
    logic [15:0]       m;
    logic              bm;
    psam_pkg::access_e k;
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    // Registers read zero after reset; the fifth offset is unmapped.
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, 12'(4 * i), 32'h0, rd, er);
      if (i < 4)
        chk("reg_reset", 32'h0, rd);
      chk("bus_error", {31'h0, i == 4}, {31'h0, er});
    end
    apb(1'b1, psam_pkg::TABLE_PAGE_OFS, 32'hFFFF_FFFF, rd, er);
    apb(1'b0, psam_pkg::TABLE_PAGE_OFS, 32'h0, rd, er);
    chk("table_page_width", 32'h0000_00FF, rd);
    apb(1'b1, psam_pkg::TABLE_PAGE_OFS, 32'h12, rd, er);
    apb(1'b1, psam_pkg::WINDOW_PAGE_OFS, 32'hA5, rd, er);
    apb(1'b1, psam_pkg::CPU_CTRL_OFS, 32'h4, rd, er);
    // Fetch addresses are even, top bit clear, and step by two.
    for (int i = 0; i < 2; i++)
    begin
      acc(psam_pkg::ACC_FETCH, 5'h00, 16'h0, 23'h2ABCDF + 23'(2 * i), 0);
      chk("fetch_addr", 24'h2ABCDE + 24'(2 * i), pq.addr);
      chk("fetch_stall", 0, stalls);
    end
    // All table read variants at an odd address inside the window range,
    // so the window must stay out of the way.
    w = mw(24'h12C357);
    for (int c = 0; c < 6; c++)
    begin
      k  = (c < 3) ? psam_pkg::ACC_TRDL : psam_pkg::ACC_TRDH;
      bm = (c % 3) != 0;
      acc(k, {bm, (c % 3) == 1, 3'b000}, 16'hC357, 23'h0, 0);
      case (c)
        0: e = w[15:0];
        1: e = {8'h00, w[15:8]};
        2: e = {8'h00, w[7:0]};
        4: e = 16'h0000;
        default: e = {8'h00, w[23:16]};
      endcase
      m = bm ? 16'h00FF : 16'hFFFF;
      chk("table_addr", 24'h12C357, pq.addr);
      chk("table_part", c >= 3, pq.highPart);
      chk("table_data", e & m, rdd & m);
      chk("table_cost", 32'h1, {stalls[30:0], rdv == 1});
    end
    // Configuration space: reads go out, writes are refused and flagged.
    apb(1'b1, psam_pkg::TABLE_PAGE_OFS, 32'h80, rd, er);
    acc(psam_pkg::ACC_TRDL, 5'h00, 16'h0004, 23'h0, 0);
    chk("cfg_read", 25'h1800004, {pq.valid, pq.addr});
    acc(psam_pkg::ACC_TWRL, 5'h00, 16'h0004, 23'h0, 0);
    chk("cfg_write_valid", 0, pq.valid);
    chk("cfg_write_flag", 1, writeRefused);
    apb(1'b0, psam_pkg::STATUS_OFS, 32'h0, rd, er);
    chk("status_flag", 32'h4, rd & 32'h4);
    apb(1'b1, psam_pkg::STATUS_OFS, 32'h4, rd, er);
    @(negedge core_clk);
    chk("flag_cleared", 0, writeRefused);
    // A user space high write goes out as a write of the upper byte.
    apb(1'b1, psam_pkg::TABLE_PAGE_OFS, 32'h12, rd, er);
    acc(psam_pkg::ACC_TWRH, 5'h00, 16'h0010, 23'h0, 0);
    chk("user_write", 27'h7120010,
        {pq.valid, pq.write, pq.highPart, pq.addr});
    chk("user_write_flag", 0, writeRefused);
    // Window reads: plain, move, costly and cheap loop iterations.
    w = mw(24'h52C321);
    for (int i = 0; i < 4; i++)
    begin
      acc(psam_pkg::ACC_DATA, WINF[i], 16'hC321, 23'h0, WINS[i]);
      chk("win_addr", 24'h52C321, pq.addr);
      chk("win_data", w[15:0], rdd);
      chk("win_valid", 1, rdv);
      chk("win_stall", WINS[i], stalls);
    end
    // Below 8000h, or with the window switched off, nothing is redirected.
    acc(psam_pkg::ACC_DATA, 5'h00, 16'h7FFF, 23'h0, 0);
    chk("below_window", 0, {stalls[30:0], pq.valid});
    apb(1'b1, psam_pkg::CPU_CTRL_OFS, 32'h0, rd, er);
    acc(psam_pkg::ACC_DATA, 5'h00, 16'h8000, 23'h0, 0);
    chk("window_off", 0, {stalls[30:0], pq.valid});
    reportAndStop();
  end
endmodule
